// [rtl/lmc_ctrl.sv]
// Controller end: APB registers, command issue, write beats and read capture
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module lmc_ctrl (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Link
	lmc_link_if.ctrl         link
);
	import lmc_pkg::*;

	typedef enum {LMC_IDLE, LMC_ISSUE, LMC_WBEAT, LMC_RWAIT, LMC_MRDW} lmc_state_e;

	lmc_state_e        state;
	lmc_cmd_e          cmd_q;
	logic [ADDR_W-1:0] addr_q;
	logic              bsl_q;
	logic              bsh_q;
	logic [DATA_W-1:0] wdata_q;
	logic [DATA_W-1:0] wbase;
	logic [MR_W-1:0]   mode_shadow;
	logic [4:0]        beat;
	logic [DATA_W-1:0] rbuf [0:15];

	wire       acc      = psel && penable;
	wire       hit_cmd  = (paddr == REG_CMD);
	wire       hit_wb   = (paddr == REG_WBASE);
	wire       hit_st   = (paddr == REG_STATUS);
	wire       hit_rb   = (paddr[7:6] == REG_RBUF[7:6]) && (paddr[1:0] == 2'h0);
	wire       mapped   = hit_cmd || hit_wb || hit_st || hit_rb;
	wire       busy     = (state != LMC_IDLE);
	wire       go       = acc && pwrite && hit_cmd && !busy;
	wire [1:0] op       = pwdata[CMD_OP_LSB +: 2];
	wire [4:0] blen     = {1'b0, lmc_burst_mask(mode_shadow[MR_BL_LSB +: 3])} + 5'h1;
	wire       last_bt  = (beat == blen - 5'h1);

	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;
	assign prdata  =
		hit_cmd ? {14'h0, cmd_q, 3'h0, addr_q} :
		hit_wb  ? {16'h0, wbase} :
		hit_st  ? {23'h0, beat, 3'h0, busy} :
		hit_rb  ? {16'h0, rbuf[paddr[5:2]]} :
		32'h0;
	assign link.cmd              = cmd_q;
	assign link.addr             = addr_q;
	assign link.bank_select_low  = bsl_q;
	assign link.bank_select_high = bsh_q;
	assign link.wdata            = wdata_q;

	// Write base
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wbase <= '0;
		else if (acc && pwrite && hit_wb)
			wbase <= pwdata[DATA_W-1:0];
	end

	// Command issue and sequencing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state       <= LMC_IDLE;
			cmd_q       <= LMC_NOP;
			addr_q      <= '0;
			bsl_q       <= 1'b0;
			bsh_q       <= 1'b0;
			wdata_q     <= '0;
			mode_shadow <= MR_RESET;
			beat        <= '0;
		end
		else
		begin
			unique case (state)
				LMC_IDLE:
				begin
					if (go)
					begin
						state <= LMC_ISSUE;
						beat  <= '0;
						unique case (op)
							2'h0:
							begin
								cmd_q       <= LMC_LMR;
								bsl_q       <= 1'b0;
								bsh_q       <= 1'b0;
								addr_q      <= {{(ADDR_W-MR_W){1'b0}}, pwdata[MR_W-1:0]};
								mode_shadow <= pwdata[MR_W-1:0];
							end
							2'h1:
							begin
								cmd_q  <= LMC_LMR;
								bsl_q  <= 1'b0;
								bsh_q  <= 1'b1;
								addr_q <= {{(ADDR_W-EMR_W){1'b0}}, pwdata[EMR_W-1:0]};
							end
							2'h2:
							begin
								cmd_q  <= LMC_WRITE;
								addr_q <= pwdata[ADDR_W-1:0];
							end
							2'h3:
							begin
								cmd_q  <= LMC_READ;
								addr_q <= pwdata[ADDR_W-1:0];
							end
						endcase
					end
				end
				LMC_ISSUE:
				begin
					cmd_q   <= LMC_NOP;
					wdata_q <= wbase;
					unique case (cmd_q)
						LMC_WRITE: state <= LMC_WBEAT;
						LMC_READ:  state <= LMC_RWAIT;
						default:   state <= LMC_MRDW;
					endcase
				end
				LMC_WBEAT:
				begin
					beat    <= beat + 5'h1;
					wdata_q <= wdata_q + {{(DATA_W-1){1'b0}}, 1'b1};
					if (last_bt)
						state <= LMC_IDLE;
				end
				LMC_RWAIT:
				begin
					if (link.rvalid)
					begin
						beat <= beat + 5'h1;
						if (last_bt)
							state <= LMC_IDLE;
					end
				end
				LMC_MRDW:
				begin
					beat <= beat + 5'h1;
					if (beat == 5'(T_MRD_CYC - 1))
					begin
						state <= LMC_IDLE;
						beat  <= '0;
					end
				end
			endcase
		end
	end

	// Read capture in arrival order
	always_ff @(posedge pclk)
	begin
		if (state == LMC_RWAIT && link.rvalid)
			rbuf[beat[3:0]] <= link.rdata;
	end

endmodule : lmc_ctrl

// [rtl/lmc_pkg.sv]
// Shared constants, command codes and field layout for the mode configuration link
package lmc_pkg;

	typedef enum logic [1:0] {LMC_NOP, LMC_LMR, LMC_WRITE, LMC_READ} lmc_cmd_e;

	localparam int ADDR_W = 13;
	localparam int DATA_W = 16;
	localparam int COL_W  = 6;

	// Standard mode register layout
	localparam int MR_BL_LSB = 0;
	localparam int MR_BT_BIT = 3;
	localparam int MR_CL_LSB = 4;
	localparam int MR_W      = 7;
	localparam logic [MR_W-1:0] MR_RESET = 7'h32;

	localparam logic [2:0] BL_CODE_2  = 3'h1;
	localparam logic [2:0] BL_CODE_4  = 3'h2;
	localparam logic [2:0] BL_CODE_8  = 3'h3;
	localparam logic [2:0] BL_CODE_16 = 3'h4;
	localparam logic [2:0] CL_CODE_2  = 3'h2;
	localparam logic [2:0] CL_CODE_3  = 3'h3;

	// Extended register layout
	localparam int EMR_PARTIAL_REFRESH_REGION_LSB = 0;
	localparam int EMR_TEMP_COMP_REFRESH_FIELD_LSB = 3;
	localparam int EMR_DS_LSB   = 5;
	localparam int EMR_W        = 8;
	localparam logic [EMR_W-1:0] EMR_RESET = 8'h00;

	localparam logic [2:0] PARTIAL_REFRESH_REGION_FULL    = 3'h0;
	localparam logic [2:0] PARTIAL_REFRESH_REGION_HALF    = 3'h1;
	localparam logic [2:0] PARTIAL_REFRESH_REGION_QUARTER = 3'h2;
	localparam logic [2:0] PARTIAL_REFRESH_REGION_EIGHTH  = 3'h5;
	localparam logic [2:0] PARTIAL_REFRESH_REGION_SIXTNTH = 3'h6;

	localparam logic [2:0] DS_FULL  = 3'h0;
	localparam logic [2:0] DS_HALF  = 3'h1;
	localparam logic [2:0] DS_3QTR  = 3'h4;

	// Controller side registers
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_WBASE  = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_RBUF   = 8'h40;
	localparam int CMD_OP_LSB   = 16;
	localparam int STAT_CNT_LSB = 4;

	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int T_MRD_NS      = 40;
	localparam int T_MRD_CYC     = (T_MRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Offset mask of a burst: length minus one
	function automatic logic [3:0] lmc_burst_mask(input logic [2:0] code);
		unique case (code)
			BL_CODE_2:  lmc_burst_mask = 4'h1;
			BL_CODE_4:  lmc_burst_mask = 4'h3;
			BL_CODE_8:  lmc_burst_mask = 4'h7;
			default:    lmc_burst_mask = 4'hf;
		endcase
	endfunction : lmc_burst_mask

endpackage : lmc_pkg

// [rtl/lmc_link_if.sv]
// Command and data link between memory controller and memory device
`timescale 1ns/1ns
interface lmc_link_if (
	input wire logic pclk
);
	import lmc_pkg::*;

	lmc_cmd_e                cmd;
	logic                    bank_select_low;
	logic                    bank_select_high;
	logic [ADDR_W-1:0]       addr;
	logic [DATA_W-1:0]       wdata;
	logic [DATA_W-1:0]       rdata;
	logic                    rvalid;

	modport mem (
		input  cmd, bank_select_low, bank_select_high, addr, wdata,
		output rdata, rvalid
	);

	modport ctrl (
		output cmd, bank_select_low, bank_select_high, addr, wdata,
		input  rdata, rvalid
	);
endinterface : lmc_link_if

// [rtl/lmc_burst_seq.sv]
// Column sequencer for one burst, sequential or interleaved, wrapping in its block
`timescale 1ns/1ns
module lmc_burst_seq (
	// Clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// Burst start
	input  wire logic                     start,
	input  wire logic [lmc_pkg::COL_W-1:0] start_col,
	input  wire logic [2:0]               bl_code,
	input  wire logic                     interleave,
	// Column stream
	output logic      [lmc_pkg::COL_W-1:0] col,
	output logic                          active,
	output logic                          last
);
	import lmc_pkg::*;

	logic [COL_W-1:0] base;
	logic [3:0]       beat;
	logic [3:0]       mask;
	logic             il;

	wire  [COL_W-1:0] wide_mask = {{(COL_W-4){1'b0}}, mask};
	wire  [COL_W-1:0] wide_beat = {{(COL_W-4){1'b0}}, beat};
	wire  [COL_W-1:0] seq_off   = (base + wide_beat) & wide_mask;
	wire  [COL_W-1:0] il_off    = (base ^ wide_beat) & wide_mask;
	wire  [COL_W-1:0] blk       = base & ~wide_mask;

	assign col  = blk | (il ? il_off : seq_off);
	assign last = active && (beat == mask);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			base   <= '0;
			beat   <= '0;
			mask   <= '0;
			il     <= 1'b0;
			active <= 1'b0;
		end
		else if (start)
		begin
			base   <= start_col;
			beat   <= '0;
			mask   <= lmc_burst_mask(bl_code);
			il     <= interleave;
			active <= 1'b1;
		end
		else if (active)
		begin
			beat   <= beat + 4'h1;
			active <= !last;
		end
	end

endmodule : lmc_burst_seq

// [rtl/lmc_mem_dev.sv]
// Memory device end: mode registers, burst ordering, read latency and small array
//
// How it works
// - Burst lengths 2,4,8,16, both ordering types.
// - Burst stays in aligned block, wraps.
// - Low address bits give first column.
// - One length for reads and writes.
// - Burst type from standard mode register.
// - Sequential: start plus k, modulo length.
// - Interleaved: start XOR k.
// - Read latency two or three clocks.
// - First read data at CL minus one.
// - Normal mode needs upper address bits zero.
// - Never load nonzero upper mode bits.
// - Extended register loads with banks 0,1.
// - Extended register held until reload or deep down.
// - Temperature field ignored, sensor rate used.
// - Five partial self refresh regions.
// - Full array accessible; unrefreshed regions lost.
// - Three drive strengths: full, three-quarter, half.
// - Standard register loads with banks 0,0.
// - Mode loads only when idle, then wait.
`timescale 1ns/1ns
module lmc_mem_dev (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Link
	lmc_link_if.mem          link,
	// Power and environment
	input  wire logic        deep_power_down,
	input  wire logic [1:0]  sensor_refresh_rate,
	// Configuration seen by the analog side
	output logic      [3:0]  refresh_banks,
	output logic             refresh_row_msb_zero,
	output logic             refresh_row_msb2_zero,
	output logic      [1:0]  self_refresh_rate,
	output logic      [2:0]  drive_strength,
	output logic             temp_comp_refresh_field_seen,
	// Current mode
	output logic      [2:0]  burst_len_sel,
	output logic             burst_interleaved,
	output logic      [1:0]  read_latency_cycles,
	output logic             mode_reserved_load
);
	import lmc_pkg::*;

	logic [MR_W-1:0]   std_mode;
	logic [EMR_W-1:0]  ext_config_reg;
	logic [DATA_W-1:0] mem [0:(1<<COL_W)-1];
	logic              read_pend;
	logic [COL_W-1:0]  pend_col;
	logic              burst_is_read;
	logic [DATA_W-1:0] rdata_q;
	logic              rvalid_q;
	logic              reserved_q;

	logic [COL_W-1:0]  seq_col;
	logic              seq_active;

	// Command decode
	wire is_lmr       = (link.cmd == LMC_LMR);
	wire std_sel      = is_lmr && !link.bank_select_low && !link.bank_select_high;
	wire ext_sel      = is_lmr && !link.bank_select_low && link.bank_select_high;
	wire upper_zero   = (link.addr[ADDR_W-1:MR_W] == '0);
	wire std_ok       = std_sel && upper_zero;
	wire std_reserved = std_sel && !upper_zero;
	wire is_read      = (link.cmd == LMC_READ);
	wire is_write     = (link.cmd == LMC_WRITE);

	// Mode fields
	wire [2:0] bl_code = std_mode[MR_BL_LSB +: 3];
	wire       bt_il   = std_mode[MR_BT_BIT];
	wire [2:0] cl_code = std_mode[MR_CL_LSB +: 3];
	wire       cl_two  = (cl_code == CL_CODE_2);

	// Burst start: writes and latency-two reads at once, latency-three reads one cycle later
	wire       seq_start = is_write || (is_read && cl_two) || read_pend;
	wire [COL_W-1:0] seq_start_col = read_pend ? pend_col : link.addr[COL_W-1:0];

	// Partial refresh decode
	wire [2:0] partial_refresh_region = ext_config_reg[EMR_PARTIAL_REFRESH_REGION_LSB +: 3];
	wire [3:0] partial_refresh_region_banks =
		(partial_refresh_region == PARTIAL_REFRESH_REGION_HALF)                                              ? 4'h3 :
		(partial_refresh_region == PARTIAL_REFRESH_REGION_QUARTER || partial_refresh_region == PARTIAL_REFRESH_REGION_EIGHTH || partial_refresh_region == PARTIAL_REFRESH_REGION_SIXTNTH) ? 4'h1 :
		4'hf;
	wire [2:0] ds_code = ext_config_reg[EMR_DS_LSB +: 3];
	wire [2:0] ds_sel  =
		(ds_code == DS_HALF) ? DS_HALF :
		(ds_code == DS_3QTR) ? DS_3QTR :
		DS_FULL;

	assign refresh_banks         = partial_refresh_region_banks;
	assign refresh_row_msb_zero  = (partial_refresh_region == PARTIAL_REFRESH_REGION_EIGHTH) || (partial_refresh_region == PARTIAL_REFRESH_REGION_SIXTNTH);
	assign refresh_row_msb2_zero = (partial_refresh_region == PARTIAL_REFRESH_REGION_SIXTNTH);
	assign self_refresh_rate     = sensor_refresh_rate;
	assign temp_comp_refresh_field_seen = 1'b0;
	assign drive_strength        = ds_sel;
	assign burst_len_sel         = bl_code;
	assign burst_interleaved     = bt_il;
	assign read_latency_cycles   = cl_two ? 2'h2 : 2'h3;
	assign mode_reserved_load    = reserved_q;
	assign link.rdata            = rdata_q;
	assign link.rvalid           = rvalid_q;

	lmc_burst_seq u_seq (
		.pclk       (pclk),
		.presetn    (presetn),
		.start      (seq_start),
		.start_col  (seq_start_col),
		.bl_code    (bl_code),
		.interleave (bt_il),
		.col        (seq_col),
		.active     (seq_active),
		.last       ()
	);

	// Standard mode register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			std_mode <= MR_RESET;
		else if (deep_power_down)
			std_mode <= MR_RESET;
		else if (std_ok)
			std_mode <= link.addr[MR_W-1:0];
	end

	// Reserved load flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			reserved_q <= 1'b0;
		else if (std_sel)
			reserved_q <= std_reserved;
	end

	// Extended register: temperature bits stored but never used
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ext_config_reg <= EMR_RESET;
		else if (deep_power_down)
			ext_config_reg <= EMR_RESET;
		else if (ext_sel)
			ext_config_reg <= link.addr[EMR_W-1:0];
	end

	// Latency three: hold the start column for one cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			read_pend <= 1'b0;
			pend_col  <= '0;
		end
		else
		begin
			read_pend <= is_read && !cl_two;
			pend_col  <= link.addr[COL_W-1:0];
		end
	end

	// Direction of the running burst
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			burst_is_read <= 1'b0;
		else if (seq_start)
			burst_is_read <= !is_write;
	end

	// Array access, not gated by the refresh region
	always_ff @(posedge pclk)
	begin
		if (seq_active && !burst_is_read)
			mem[seq_col] <= link.wdata;
	end

	// Read data
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdata_q  <= '0;
			rvalid_q <= 1'b0;
		end
		else
		begin
			rvalid_q <= seq_active && burst_is_read;
			if (seq_active && burst_is_read)
				rdata_q <= mem[seq_col];
		end
	end

endmodule : lmc_mem_dev

// [dv/lmc_link_asserts.sv]
// Checker on the link: command spacing, mode loads and read data timing
`timescale 1ns/1ns
module lmc_link_asserts
	import lmc_pkg::*;
(
	// Clock and reset
	input wire logic              pclk,
	input wire logic              presetn,
	// Link
	input wire lmc_pkg::lmc_cmd_e cmd,
	input wire logic              bank_select_low,
	input wire logic              bank_select_high,
	input wire logic [12:0]       addr,
	input wire logic              rvalid
);
	logic       cl3;
	logic [4:0] bl_len;
	logic [4:0] beats;
	wire        std_load = cmd == LMC_LMR && !bank_select_low && !bank_select_high
		&& addr[12:7] == 6'h00;
	wire  [4:0] next_bl_len = (addr[2:0] == BL_CODE_2) ? 5'h02 :
		(addr[2:0] == BL_CODE_4) ? 5'h04 : (addr[2:0] == BL_CODE_8) ? 5'h08 : 5'h10;

	// Mirror of the programmed length and latency
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			{cl3, bl_len} <= {1'b1, 5'h04};
		else if (std_load)
			{cl3, bl_len} <= {addr[6:4] != CL_CODE_2, next_bl_len};

	// Beats seen since the last read command
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			beats <= 5'h00;
		else if (cmd == LMC_READ)
			beats <= 5'h00;
		else if (rvalid)
			beats <= beats + 5'h01;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_first_cl2;
		!rvalid ##1 rvalid;
	endsequence
	sequence s_first_cl3;
		!rvalid[*2] ##1 rvalid;
	endsequence
	sequence s_mrd_gap;
		(cmd == LMC_NOP)[*2];
	endsequence

	AST_RD_CL3: assert property (cmd == LMC_READ && cl3 |=> s_first_cl3)
		else $error("first read beat not two edges after read at latency three");
	AST_RD_CL2: assert property (cmd == LMC_READ && !cl3 |=> s_first_cl2)
		else $error("first read beat not one edge after read at latency two");
	AST_RD_CAUSE: assert property ($rose(rvalid) |->
		(cl3 ? $past(cmd, 3) : $past(cmd, 2)) == LMC_READ)
		else $error("read data without a read command at the set latency");
	AST_RD_BEATS: assert property ($fell(rvalid) |-> beats == bl_len)
		else $error("read burst beat count differs from programmed length");
	AST_CMD_PULSE: assert property (cmd != LMC_NOP |=> cmd == LMC_NOP)
		else $error("command held for more than one cycle");
	AST_LMR_GAP: assert property (cmd == LMC_LMR |=> s_mrd_gap)
		else $error("operation issued inside the mode load delay");
	AST_STD_UPPER: assert property (cmd == LMC_LMR && !bank_select_high |->
		addr[12:7] == 6'h00)
		else $error("standard load with reserved upper bits");
	AST_LMR_BANKS: assert property (cmd == LMC_LMR |-> !bank_select_low)
		else $error("mode load with bank select low set");
endmodule : lmc_link_asserts

// [dv/tb_lpddr_mode_config_burst_order.sv]
// Regression bench joining controller and memory ends over the link
`timescale 1ns/1ns
module tb_lpddr_mode_config_burst_order;
	import lmc_pkg::*;

	logic        pclk            = 1'b0;
	logic        presetn         = 1'b0;
	logic        psel            = 1'b0;
	logic        penable         = 1'b0;
	logic        pwrite          = 1'b0;
	logic [7:0]  paddr           = 8'h00;
	logic [31:0] pwdata          = 32'h0;
	logic        deep_power_down = 1'b0;
	logic [1:0]  sensor_rate     = 2'h0;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire  [3:0]  refresh_banks;
	wire         msb_zero;
	wire         msb2_zero;
	wire  [1:0]  self_rate;
	wire  [2:0]  drive_strength;
	wire         temp_seen;
	wire  [2:0]  burst_len_sel;
	wire         burst_interleaved;
	wire  [1:0]  read_latency_cycles;
	wire         reserved_load;
	int          n_fail          = 0;
	int          num_checks      = 0;
	logic [15:0] model [64];
	logic [31:0] rd;
	logic        err;
	logic [2:0]  partial_refresh_region_tab [5]    = '{PARTIAL_REFRESH_REGION_FULL, PARTIAL_REFRESH_REGION_HALF, PARTIAL_REFRESH_REGION_QUARTER, PARTIAL_REFRESH_REGION_EIGHTH, PARTIAL_REFRESH_REGION_SIXTNTH};
	logic [5:0]  region_tab [5]  = '{6'h3c, 6'h0c, 6'h04, 6'h06, 6'h07};
	logic [2:0]  ds_tab [3]      = '{DS_FULL, DS_3QTR, DS_HALF};

	always #10 pclk = ~pclk;

	lmc_link_if link (.pclk(pclk));
	lmc_mem_dev i_lmc_mem_dev (.pclk(pclk), .presetn(presetn), .link(link),
		.deep_power_down(deep_power_down), .sensor_refresh_rate(sensor_rate),
		.refresh_banks(refresh_banks), .refresh_row_msb_zero(msb_zero),
		.refresh_row_msb2_zero(msb2_zero), .self_refresh_rate(self_rate),
		.drive_strength(drive_strength), .temp_comp_refresh_field_seen(temp_seen),
		.burst_len_sel(burst_len_sel), .burst_interleaved(burst_interleaved),
		.read_latency_cycles(read_latency_cycles), .mode_reserved_load(reserved_load));
	lmc_ctrl i_lmc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	lmc_link_asserts i_lmc_link_asserts (.pclk(pclk), .presetn(presetn), .cmd(link.cmd),
		.bank_select_low(link.bank_select_low), .bank_select_high(link.bank_select_high),
		.addr(link.addr), .rvalid(link.rvalid));

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			n_fail++;
			tally_and_finish();
		end
		@(posedge pclk);
	endtask : apb

	task automatic do_cmd(input logic [1:0] op, input logic [12:0] a);
		int n;
		apb(1'b1, REG_CMD, {14'h0, op, 3'h0, a});
		n = 0;
		do
		begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end
		while (rd[0] !== 1'b0 && n < 100);
		if (rd[0] !== 1'b0)
		begin
			n_fail++;
			tally_and_finish();
		end
	endtask : do_cmd

	task automatic set_mode(input logic [2:0] bc, input logic il, input logic [2:0] cc);
		do_cmd(2'h0, {6'h0, cc, il, bc});
		chk({10'h0, burst_interleaved, read_latency_cycles, burst_len_sel},
			{10'h0, il, cc[1:0], bc}, "mode outputs");
		chk({15'h0, reserved_load}, 16'h0000, "reserved flag");
	endtask : set_mode

	function automatic int col_at(int s, int k, int bl, int il);
		return (s & ~(bl - 1)) | ((il != 0 ? (s ^ k) : (s + k)) & (bl - 1));
	endfunction : col_at

	task automatic wr_burst(input logic [12:0] s, input logic [15:0] base, input int bl,
		input int il);
		apb(1'b1, REG_WBASE, {16'h0, base});
		do_cmd(2'h2, s);
		for (int k = 0; k < bl; k++)
			model[col_at(int'(s), k, bl, il)] = base + 16'(k);
	endtask : wr_burst

	initial
	begin
		#1000000;
		n_fail++;
		tally_and_finish();
	end

	initial
	begin
		int s;
		int bl;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({13'h0, burst_len_sel}, {13'h0, BL_CODE_4}, "reset length");
		for (int i = 0; i < 5; i++)
		begin
			sensor_rate <= 2'(i);
			do_cmd(2'h1, {5'h0, ds_tab[i % 3], ~2'(i), partial_refresh_region_tab[i]});
			chk({10'h0, refresh_banks, msb_zero, msb2_zero}, {10'h0, region_tab[i]},
				"region");
			chk({13'h0, drive_strength}, {13'h0, ds_tab[i % 3]}, "drive");
			chk({13'h0, temp_seen, self_rate}, {14'h0, 2'(i)}, "temp field");
		end
		do_cmd(2'h0, 13'h0032);
		chk({10'h0, refresh_banks, msb_zero, msb2_zero}, 16'h0007, "ext kept");
		deep_power_down <= 1'b1;
		repeat (2) @(posedge pclk);
		deep_power_down <= 1'b0;
		@(posedge pclk);
		chk({10'h0, refresh_banks, msb_zero, msb2_zero}, 16'h003c, "ext cleared");
		apb(1'b0, 8'h20, 32'h0);
		chk({15'h0, err}, 16'h0001, "unmapped error");
		$display("Test config done");
		do_cmd(2'h1, {5'h0, DS_FULL, 2'h0, PARTIAL_REFRESH_REGION_SIXTNTH});
		set_mode(BL_CODE_16, 1'b0, CL_CODE_3);
		for (int j = 0; j < 4; j++)
			wr_burst(13'(16 * j), 16'h1000 + 16'(16 * j), 16, 0);
		set_mode(BL_CODE_4, 1'b1, CL_CODE_3);
		wr_burst(13'h0025, 16'h2000, 4, 1);
		$display("Test fill done");
		for (int b = 1; b <= 4; b++)
			for (int il = 0; il < 2; il++)
				for (int cl = 2; cl <= 3; cl++)
				begin
					bl = 1 << b;
					s = (b * 13 + il * 7 + cl * 5) & 63;
					set_mode(3'(b), il[0], 3'(cl));
					do_cmd(2'h3, 13'(s));
					chk({11'h0, rd[8:4]}, 16'(bl), "status beats");
					for (int k = 0; k < bl; k++)
					begin
						apb(1'b0, REG_RBUF + 8'(4 * k), 32'h0);
						chk(rd[15:0], model[col_at(s, k, bl, il)], "beat");
					end
				end
		$display("Test burst order done");
		tally_and_finish();
	end
endmodule : tb_lpddr_mode_config_burst_order
